/* File: hdl/pmi_events.sv */
// edge, start and stop detection on the filtered lines
`timescale 1ns/1ps
module pmi_events
    import pmi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    pmi_line_if.detect line
);
    typedef struct packed {
        logic scl_q;
        logic sda_q;
    } pmi_ev_type;

    pmi_ev_type st;
    pmi_ev_type next_st;

    // remember last line levels
    always_comb
    begin
        next_st.scl_q = line.scl;
        next_st.sda_q = line.sda;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            st <= '{scl_q: 1'b1, sda_q: 1'b1};
        else
            st <= next_st;
    end

    // data moving while the clock stays high marks start or stop
    assign line.scl_rise = line.scl && !st.scl_q;
    assign line.scl_fall = !line.scl && st.scl_q;
    assign line.start = line.scl && st.scl_q && st.sda_q && !line.sda;
    assign line.stop = line.scl && st.scl_q && !st.sda_q && line.sda;
endmodule

/* File: hdl/pmi_filter.sv */
// two-flop synchroniser and spike filter for one bus line
`timescale 1ns/1ps
module pmi_filter
    import pmi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic raw,
    input wire logic hs_mode,
    output logic clean
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic [3:0] cnt;
        logic out;
    } pmi_filt_type;

    pmi_filt_type st;
    pmi_filt_type next_st;
    logic [3:0] limit;

    // a new level must hold for the spike time before it is passed on
    always_comb
    begin
        next_st = st;
        limit = hs_mode ? FILT_HS_LIMIT : FILT_FS_LIMIT;
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        if (st.s2 == st.out)
            next_st.cnt = 4'h0;
        else if (st.cnt + 4'h1 >= limit)
        begin
            next_st.out = st.s2;
            next_st.cnt = 4'h0;
        end
        else
            next_st.cnt = st.cnt + 4'h1;
    end

    // idle bus is high, so reset to high
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            st <= '{s1: 1'b1, s2: 1'b1, cnt: 4'h0, out: 1'b1};
        else
            st <= next_st;
    end

    assign clean = st.out;
endmodule

/* File: hdl/pmi_i2c_slave.sv */
// two-wire serial slave front end of the power-management device
//
// Contract
// RULE1: one bit per clock; data changes while clock high are control.
// RULE2: byte is eight bits MSB first plus one acknowledge bit.
// RULE3: start is data falling, stop is data rising, clock high.
// RULE4: repeated start behaves exactly like start, new address phase.
// RULE5: after stop or foreign address, ignore clocks until next start.
// RULE6: acknowledge drives data low through the ninth clock high.
// RULE7: not-acknowledge leaves data released through the ninth clock.
// RULE8: master should watch acknowledges and retry later on failure.
// RULE9: every register pointer value is acknowledged.
// RULE10: only seven-bit slave addresses are matched.
// RULE11: main address 0x48 or 0x40 by option; last bit is read.
// RULE12: address 0x49 acknowledged only while test mode unlocked.
// RULE13: no other slave address is acknowledged.
// RULE14: the clock line is never held low.
// RULE15: general call address is never acknowledged.
// RULE16: works at any clock rate up to high-speed range.
// RULE17: speeds up to 1MHz need no announcing sequence.
// RULE18: filters return to up-to-1MHz mode at power-up and stop.
// RULE19: high-speed filters only after the high-speed master code.
// RULE20: both lines released when the interface is idle.
// RULE21: both supplies under voltage keeps both lines released.
// RULE22: master ends with not-acknowledge and stop, or repeated start.
// RULE23: master code 0000_1xxx is not acknowledged, enters high speed.
// RULE24: stop leaves the register pointer unchanged.
// RULE25: read returns eight bits from the pointed register.
// RULE26: write data bytes acknowledged, stored at successive registers.
// RULE27: both lines synchronised and spike filtered before use.
`timescale 1ns/1ps
module pmi_i2c_slave
    import pmi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_select,
    input wire logic test_unlock,
    input wire logic io_supply_undervoltage,
    input wire logic system_supply_undervoltage,
    output logic hs_mode,
    output logic [7:0] reg_ptr,
    output logic wr_strobe,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic rd_strobe,
    input wire logic [7:0] rd_data
);
    typedef struct packed {
        pmi_state_type st;
        pmi_phase_type ph;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic acked;
        logic drive;
        logic hs;
        logic [7:0] ptr;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic wr_stb;
        logic rd_stb;
        logic [1:0] uv_s1;
        logic [1:0] uv_s2;
        logic ad_s1;
        logic ad_s2;
    } pmi_core_type;

    pmi_core_type r;
    pmi_core_type next_r;
    pmi_line_if line ();
    logic [6:0] main_addr;
    logic uv_both;
    logic addr_hit;

    // RULE27 RULE16 line filtering, width set by mode only
    pmi_filter scl_filt (
        .clk(clk),
        .rst_b(rst_b),
        .raw(scl_in),
        .hs_mode(r.hs),
        .clean(line.scl)
    );

    // RULE27 line filtering
    pmi_filter sda_filt (
        .clk(clk),
        .rst_b(rst_b),
        .raw(sda_in),
        .hs_mode(r.hs),
        .clean(line.sda)
    );

    // RULE3 condition detection
    pmi_events events (
        .clk(clk),
        .rst_b(rst_b),
        .line(line)
    );

    // RULE11 address option select
    assign main_addr = r.ad_s2 ? ADDR_MAIN_SEL1 : ADDR_MAIN_SEL0;
    assign uv_both = &r.uv_s2;
    // RULE10 RULE12 seven-bit match, test address gated
    assign addr_hit = (r.sh[7:1] == main_addr)
                      || (test_unlock && r.sh[7:1] == ADDR_TEST);

    // frame sequencing, one step per filtered clock edge
    always_comb
    begin
        next_r = r;
        next_r.wr_stb = 1'b0;
        next_r.rd_stb = 1'b0;
        next_r.uv_s1 = {io_supply_undervoltage, system_supply_undervoltage};
        next_r.uv_s2 = r.uv_s1;
        next_r.ad_s1 = addr_select;
        next_r.ad_s2 = r.ad_s1;
        // RULE3 stop ends the frame
        if (line.stop)
        begin
            // RULE24 pointer kept
            next_r.st = PMI_IGNORE;
            // RULE17 RULE18 back to slow filters
            next_r.hs = 1'b0;
            next_r.drive = 1'b0;
        end
        // RULE4 start or repeated start
        else if (line.start)
        begin
            next_r.st = PMI_RX;
            next_r.ph = PMI_PH_ADDR;
            next_r.cnt = 4'h0;
            next_r.drive = 1'b0;
        end
        else
        begin
            case (r.st)
                // RULE5 clocks ignored here
                PMI_IGNORE:
                begin
                    next_r.drive = 1'b0;
                end
                PMI_RX:
                begin
                    // RULE1 sample on clock rise, MSB first
                    if (line.scl_rise && r.cnt < BITS_PER_BYTE)
                    begin
                        next_r.sh = {r.sh[6:0], line.sda};
                        next_r.cnt = r.cnt + 4'h1;
                    end
                    // RULE2 decide after eighth bit
                    else if (line.scl_fall && r.cnt == BITS_PER_BYTE)
                    begin
                        case (r.ph)
                            PMI_PH_ADDR:
                            begin
                                // RULE15 general call refused
                                if (r.sh == GENERAL_CALL)
                                    next_r.st = PMI_IGNORE;
                                // RULE19 RULE23 master code, no ack
                                else if (r.sh[7:3] == HS_CODE_TOP)
                                begin
                                    next_r.hs = 1'b1;
                                    next_r.st = PMI_IGNORE;
                                end
                                // RULE13 only own addresses acknowledged
                                else if (addr_hit)
                                begin
                                    next_r.drive = 1'b1;
                                    next_r.rw = r.sh[0];
                                    next_r.st = PMI_ACK;
                                end
                                else
                                    next_r.st = PMI_IGNORE;
                            end
                            PMI_PH_PTR:
                            begin
                                // RULE9 every pointer acknowledged
                                next_r.ptr = r.sh;
                                next_r.ph = PMI_PH_DATA;
                                next_r.drive = 1'b1;
                                next_r.st = PMI_ACK;
                            end
                            default:
                            begin
                                // RULE26 store and advance pointer
                                next_r.wr_stb = 1'b1;
                                next_r.wr_addr = r.ptr;
                                next_r.wr_data = r.sh;
                                next_r.ptr = r.ptr + 8'h01;
                                next_r.drive = 1'b1;
                                next_r.st = PMI_ACK;
                            end
                        endcase
                    end
                end
                PMI_ACK:
                begin
                    // RULE6 hold low until ninth clock falls
                    if (line.scl_fall)
                    begin
                        next_r.drive = 1'b0;
                        next_r.cnt = 4'h0;
                        if (r.ph == PMI_PH_ADDR && r.rw)
                        begin
                            next_r.st = PMI_TX_LOAD;
                            next_r.rd_stb = 1'b1;
                        end
                        else
                        begin
                            if (r.ph == PMI_PH_ADDR)
                                next_r.ph = PMI_PH_PTR;
                            next_r.st = PMI_RX;
                        end
                    end
                end
                PMI_TX_LOAD:
                begin
                    // RULE25 fetch pointed register
                    next_r.sh = rd_data;
                    next_r.ptr = r.ptr + 8'h01;
                    next_r.drive = !rd_data[7];
                    next_r.cnt = 4'h0;
                    next_r.st = PMI_TX;
                end
                PMI_TX:
                begin
                    // RULE2 shift out on clock fall
                    if (line.scl_fall)
                    begin
                        if (r.cnt == BITS_PER_BYTE - 4'h1)
                        begin
                            next_r.drive = 1'b0;
                            next_r.st = PMI_TX_ACK;
                        end
                        else
                        begin
                            next_r.sh = {r.sh[6:0], 1'b0};
                            next_r.drive = !r.sh[6];
                            next_r.cnt = r.cnt + 4'h1;
                        end
                    end
                end
                PMI_TX_ACK:
                begin
                    // RULE7 master answer sampled on ninth rise
                    if (line.scl_rise)
                        next_r.acked = !line.sda;
                    else if (line.scl_fall)
                    begin
                        if (r.acked)
                        begin
                            next_r.st = PMI_TX_LOAD;
                            next_r.rd_stb = 1'b1;
                        end
                        else
                            next_r.st = PMI_IGNORE;
                    end
                end
                default:
                begin
                    next_r.st = PMI_IGNORE;
                    next_r.drive = 1'b0;
                end
            endcase
        end
        // RULE21 undervoltage releases the line
        if (uv_both)
            next_r.drive = 1'b0;
    end

    // RULE18 power-up state: slow filters, idle
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            r <= '0;
            r.st <= PMI_IGNORE;
            r.ph <= PMI_PH_ADDR;
            r.ptr <= PTR_RESET;
        end
        else
            r <= next_r;
    end

    // open-drain drive of data; RULE14 clock never driven
    assign scl_out = 1'b0;
    assign scl_oe = 1'b0;
    assign sda_out = 1'b0;
    // RULE20 drives only during acknowledge or read data
    assign sda_oe = r.drive;
    assign hs_mode = r.hs;
    assign reg_ptr = r.ptr;
    assign wr_strobe = r.wr_stb;
    assign wr_addr = r.wr_addr;
    assign wr_data = r.wr_data;
    assign rd_strobe = r.rd_stb;

    // checks of the bus behaviour
    logic byte_done;
    assign byte_done = (r.st == PMI_RX) && line.scl_fall
                       && r.cnt == BITS_PER_BYTE && !line.start && !line.stop;

    a_no_stretch: assert property ( // RULE14
        @(posedge clk) disable iff (!rst_b) !scl_oe)
        else $error("clock line driven");
    a_uv_release: assert property ( // RULE21
        @(posedge clk) disable iff (!rst_b) uv_both |=> !sda_oe)
        else $error("data driven under undervoltage");
    a_stop_slow_filter: assert property ( // RULE18
        @(posedge clk) disable iff (!rst_b) line.stop |=> !hs_mode)
        else $error("high speed kept after stop");
    a_stop_ptr_kept: assert property ( // RULE24
        @(posedge clk) disable iff (!rst_b)
        line.stop |=> reg_ptr == $past(reg_ptr))
        else $error("pointer changed by stop");
    a_gencall_nack: assert property ( // RULE15
        @(posedge clk) disable iff (!rst_b)
        byte_done && r.ph == PMI_PH_ADDR && r.sh == GENERAL_CALL
        |=> !sda_oe [*2])
        else $error("general call acknowledged");
    a_main_addr_ack: assert property ( // RULE11
        @(posedge clk) disable iff (!rst_b)
        byte_done && r.ph == PMI_PH_ADDR && r.sh[7:1] == main_addr
        && !uv_both |=> sda_oe && r.st == PMI_ACK)
        else $error("main address not acknowledged");
    a_test_addr_lock: assert property ( // RULE12
        @(posedge clk) disable iff (!rst_b)
        byte_done && r.ph == PMI_PH_ADDR && r.sh[7:1] == ADDR_TEST
        && !test_unlock |=> !sda_oe && r.st == PMI_IGNORE)
        else $error("locked test address acknowledged");
    a_ptr_ack: assert property ( // RULE9
        @(posedge clk) disable iff (!rst_b)
        byte_done && r.ph == PMI_PH_PTR && !uv_both
        |=> sda_oe && reg_ptr == $past(r.sh))
        else $error("pointer byte not acknowledged");
    a_hs_entry: assert property ( // RULE23
        @(posedge clk) disable iff (!rst_b)
        byte_done && r.ph == PMI_PH_ADDR && r.sh[7:3] == HS_CODE_TOP
        |=> hs_mode && !sda_oe)
        else $error("master code mishandled");
    a_ignore_hold: assert property ( // RULE5
        @(posedge clk) disable iff (!rst_b)
        r.st == PMI_IGNORE && !line.start |=> r.st == PMI_IGNORE && !sda_oe)
        else $error("activity while ignoring");
    a_write_advance: assert property ( // RULE26
        @(posedge clk) disable iff (!rst_b)
        wr_strobe |-> reg_ptr == wr_addr + 8'h01)
        else $error("pointer not advanced on write");

    c_write: cover property (@(posedge clk) disable iff (!rst_b) wr_strobe);
    c_read: cover property (
        @(posedge clk) disable iff (!rst_b) rd_strobe ##1 r.st == PMI_TX);
    c_hs: cover property (@(posedge clk) disable iff (!rst_b) $rose(hs_mode));
    c_burst_read: cover property (
        @(posedge clk) disable iff (!rst_b)
        r.st == PMI_TX_ACK && line.scl_fall && r.acked);
endmodule

/* File: hdl/pmi_line_if.sv */
// filtered bus lines and their events, shared inside the slave
`timescale 1ns/1ps
interface pmi_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    modport detect (input scl, input sda,
                    output scl_rise, output scl_fall, output start,
                    output stop);
    modport core (input scl, input sda, input scl_rise, input scl_fall,
                  input start, input stop);
endinterface

/* File: hdl/pmi_pkg.sv */
// shared constants and types of the power-management serial slave
package pmi_pkg;
    // clock and input filter timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int FS_SPIKE_NS = 50;
    localparam int HS_SPIKE_NS = 10;
    localparam int FS_SPIKE_CYC = (FS_SPIKE_NS / CLK_PERIOD_NS < 1) ? 1
                                  : FS_SPIKE_NS / CLK_PERIOD_NS;
    localparam int HS_SPIKE_CYC = (HS_SPIKE_NS / CLK_PERIOD_NS < 1) ? 1
                                  : HS_SPIKE_NS / CLK_PERIOD_NS;
    localparam logic [3:0] FILT_FS_LIMIT = 4'(FS_SPIKE_CYC);
    localparam logic [3:0] FILT_HS_LIMIT = 4'(HS_SPIKE_CYC);
    // slave addresses and codes
    localparam logic [6:0] ADDR_MAIN_SEL1 = 7'h48;
    localparam logic [6:0] ADDR_MAIN_SEL0 = 7'h40;
    localparam logic [6:0] ADDR_TEST = 7'h49;
    localparam logic [7:0] GENERAL_CALL = 8'h00;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // reset values
    localparam logic [7:0] PTR_RESET = 8'h00;
    // frame states, one-hot
    typedef enum logic [5:0] {
        PMI_IGNORE  = 6'h01,
        PMI_RX      = 6'h02,
        PMI_ACK     = 6'h04,
        PMI_TX_LOAD = 6'h08,
        PMI_TX      = 6'h10,
        PMI_TX_ACK  = 6'h20
    } pmi_state_type;
    // meaning of the byte being received
    typedef enum logic [2:0] {
        PMI_PH_ADDR = 3'h1,
        PMI_PH_PTR  = 3'h2,
        PMI_PH_DATA = 3'h4
    } pmi_phase_type;
endpackage

/* File: tb/pmi_bus_master.sv */
// behavioural bus master driving the two open-drain lines of the slave
`timescale 1ns/1ps
module pmi_bus_master
(
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_oe,
    output logic sda_oe
);
    // low is longer than high so the slave's late ack release lands early
    localparam int LOW_CYC = 12;
    localparam int HIGH_CYC = 8;

    initial
    begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // data set in low, watched through whole high
    task automatic bit_cycle(input logic pull, output logic lo,
                             output logic hi);
        wait_clk(LOW_CYC / 2);
        sda_oe = pull;
        wait_clk(LOW_CYC / 2);
        scl_oe = 1'b0;
        lo = 1'b1;
        hi = 1'b1;
        repeat (HIGH_CYC)
        begin
            @(negedge clk);
            lo = lo & (sda === 1'b0);
            hi = hi & (sda === 1'b1);
        end
        scl_oe = 1'b1;
    endtask

    // start, repeated when the clock is already held low
    task automatic start_cond();
        if (scl_oe)
        begin
            wait_clk(LOW_CYC / 2);
            sda_oe = 1'b0;
            wait_clk(LOW_CYC / 2);
            scl_oe = 1'b0;
        end
        wait_clk(HIGH_CYC);
        sda_oe = 1'b1;
        wait_clk(HIGH_CYC);
        scl_oe = 1'b1;
    endtask

    task automatic stop_cond();
        wait_clk(LOW_CYC / 2);
        sda_oe = 1'b1;
        wait_clk(LOW_CYC / 2);
        scl_oe = 1'b0;
        wait_clk(HIGH_CYC);
        sda_oe = 1'b0;
        wait_clk(HIGH_CYC);
    endtask

    // eight bits msb first, ack: 1 low, 0 high, x mixed
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic lo, hi;
        for (int i = 7; i >= 0; i--)
            bit_cycle(~b[i], lo, hi);
        bit_cycle(1'b0, lo, hi);
        ack = lo ? 1'b1 : (hi ? 1'b0 : 1'bx);
    endtask

    // read byte, then master ack or not-ack
    task automatic get_byte(input logic m_ack, output logic [7:0] b);
        logic lo, hi;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cycle(1'b0, lo, hi);
            b[i] = lo ? 1'b0 : (hi ? 1'b1 : 1'bx);
        end
        bit_cycle(m_ack, lo, hi);
    endtask
endmodule

/* File: tb/test_pmic_i2c_slave_interface.sv */
// self-checking bench of the power-management serial slave
`timescale 1ns/1ps
module test_pmic_i2c_slave_interface;
    import pmi_pkg::*;
    // {select, unlock, ack expected, address byte}
    localparam logic [10:0] ADDR_TAB [7] = '{11'h590, 11'h480, 11'h492,
        11'h792, 11'h400, 11'h180, 11'h090};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic addr_select = 1'b1;
    logic test_unlock = 1'b0;
    logic io_supply_undervoltage = 1'b0;
    logic system_supply_undervoltage = 1'b0;
    logic m_scl_oe, m_sda_oe, scl, sda, scl_oe, sda_oe;
    logic hs_mode, wr_strobe, rd_strobe, ack;
    logic [7:0] reg_ptr, wr_addr, wr_data, rd_data, rb;
    logic [7:0] regs [256];
    int n_errors = 0;
    int total_checks = 0;
    int n_wr = 0;
    int n_rd = 0;

    always #5 clk = ~clk;
    // open-drain lines with pull-ups
    assign scl = ~(m_scl_oe | scl_oe);
    assign sda = ~(m_sda_oe | sda_oe);
    assign rd_data = regs[reg_ptr];
    // register file behind the slave
    always @(posedge clk)
    begin
        if (wr_strobe === 1'b1)
        begin
            regs[wr_addr] <= wr_data;
            n_wr <= n_wr + 1;
        end
        if (rd_strobe === 1'b1)
            n_rd <= n_rd + 1;
    end

    pmi_i2c_slave u_pmi_i2c_slave (.clk(clk), .rst_b(rst_b),
        .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
        .sda_out(), .sda_oe(sda_oe), .addr_select(addr_select),
        .test_unlock(test_unlock),
        .io_supply_undervoltage(io_supply_undervoltage),
        .system_supply_undervoltage(system_supply_undervoltage),
        .hs_mode(hs_mode), .reg_ptr(reg_ptr), .wr_strobe(wr_strobe),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_strobe(rd_strobe),
        .rd_data(rd_data));
    pmi_bus_master u_pmi_bus_master (.clk(clk), .scl(scl), .sda(sda),
        .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t got 0x%h expected 0x%h", $time, got,
                     exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        check8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // clock line watched every cycle
    always @(negedge clk)
        if (rst_b === 1'b1)
            check1(scl_oe, 1'b0);

    task automatic send(input logic [7:0] b, input logic exp);
        u_pmi_bus_master.put_byte(b, ack);
        check1(ack, exp);
    endtask

    // multi-byte write across the pointer wrap
    task automatic t_write();
        int w0;
        w0 = n_wr;
        u_pmi_bus_master.start_cond();
        send(8'h90, 1'b1);
        send(8'hFE, 1'b1);
        send(8'hA5, 1'b1);
        send(8'h3C, 1'b1);
        u_pmi_bus_master.stop_cond();
        check8(regs[8'hFE], 8'hA5);
        check8(regs[8'hFF], 8'h3C);
        check8(8'(n_wr - w0), 8'h02);
        check8(reg_ptr, 8'h00);
        check1(sda_oe, 1'b0);
        $display("test write done");
    endtask

    // pointer set, repeated start, two sequential reads
    task automatic t_read();
        int r0;
        r0 = n_rd;
        u_pmi_bus_master.start_cond();
        send(8'h90, 1'b1);
        send(8'h10, 1'b1);
        u_pmi_bus_master.start_cond();
        send(8'h91, 1'b1);
        u_pmi_bus_master.get_byte(1'b1, rb);
        check8(rb, 8'h4A);
        u_pmi_bus_master.get_byte(1'b0, rb);
        check8(rb, 8'h4B);
        u_pmi_bus_master.stop_cond();
        check8(reg_ptr, 8'h12);
        check8(8'(n_rd - r0), 8'h02);
        $display("test read done");
    endtask

    // address options; a refused address leaves the next byte unanswered
    task automatic t_addr();
        int w0;
        w0 = n_wr;
        for (int i = 0; i < 7; i++)
        begin
            addr_select = ADDR_TAB[i][10];
            test_unlock = ADDR_TAB[i][9];
            repeat (4) @(negedge clk);
            u_pmi_bus_master.start_cond();
            send(ADDR_TAB[i][7:0], ADDR_TAB[i][8]);
            send(8'h90, ADDR_TAB[i][8]);
            u_pmi_bus_master.stop_cond();
            check1(hs_mode, 1'b0);
        end
        check8(8'(n_wr - w0), 8'h00);
        addr_select = 1'b1;
        test_unlock = 1'b0;
        $display("test address done");
    endtask

    // master code, repeated start keeps high speed, stop ends it
    task automatic t_hs();
        u_pmi_bus_master.start_cond();
        send(8'h0B, 1'b0);
        check1(hs_mode, 1'b1);
        u_pmi_bus_master.start_cond();
        send(8'h90, 1'b1);
        send(8'h20, 1'b1);
        send(8'h77, 1'b1);
        check1(hs_mode, 1'b1);
        u_pmi_bus_master.stop_cond();
        repeat (4) @(negedge clk);
        check1(hs_mode, 1'b0);
        check8(regs[8'h20], 8'h77);
        $display("test high speed done");
    endtask

    // both supplies low releases the line, one alone does not
    task automatic t_uv();
        io_supply_undervoltage = 1'b1;
        system_supply_undervoltage = 1'b1;
        repeat (5) @(negedge clk);
        u_pmi_bus_master.start_cond();
        send(8'h90, 1'b0);
        u_pmi_bus_master.stop_cond();
        system_supply_undervoltage = 1'b0;
        repeat (5) @(negedge clk);
        u_pmi_bus_master.start_cond();
        send(8'h90, 1'b1);
        u_pmi_bus_master.stop_cond();
        io_supply_undervoltage = 1'b0;
        $display("test undervoltage done");
    endtask

    // hang guard
    initial
    begin
        repeat (100000) @(posedge clk);
        n_errors++;
        finish_test();
    end

    // main sequence
    initial
    begin
        for (int i = 0; i < 256; i++)
            regs[i] = 8'(i) ^ 8'h5A;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        check1(sda_oe, 1'b0);
        check8(reg_ptr, 8'h00);
        t_write();
        t_read();
        t_addr();
        t_hs();
        t_uv();
        finish_test();
    end
endmodule
